// ### src/relay_defs.svh
`ifndef RELAY_DEFS_SVH
`define RELAY_DEFS_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_SP_BASE       8'h04
`define REG_SP_STRIDE     8'h0c
`define REG_SP_CFG        8'h00
`define REG_SP_THR        8'h04
`define REG_SP_TIME       8'h08
`define REG_DIV           8'h1c
`define REG_STATUS        8'h20

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define CTRL_ZHOLD        0
`define CTRL_TXMODE_LO    1
`define CTRL_IN_TEST      3
`define CTRL_OUT_TEST     4
`define CTRL_OUT_BITS_LO  5
`define CFG_SRC_LO        0
`define CFG_NC            2
`define CFG_NEG           3
`define CFG_STABLE        4
`define CFG_HYST_LO       16
`define TIME_MAXON_LO     0
`define TIME_DELAY_LO     16
`define STAT_INPUTS_LO    0
`define STAT_RELAY_LO     2
`define STAT_ACTIVE_LO    4
`define STAT_STABLE       6

// ---------------------------------------------------------------------------
// Reset values and minimum transmit change in divisions
// ---------------------------------------------------------------------------
`define RST_SRC           2'h1
`define RST_HYST          10'h002
`define RST_TIME          10'h000
`define RST_DIV           16'h0001
`define RST_THR           24'h000000
`define CHANGE_DIVS       16'h0014

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define CLK_PERIOD_NS     20
`define TICK_NS           100000000
`define TICK_MS           100
`define ZERO_HOLD_MS      5000
`define ZERO_HOLD_TICKS   (`ZERO_HOLD_MS / `TICK_MS)

`endif

// ### src/relay_pkg.sv
package relay_pkg;

  localparam int WEIGHT_W = 24;
  localparam int NUM_SP   = 2;

  typedef enum logic [1:0] {SRC_NET, SRC_GROSS, SRC_PEAK} src_type;
  typedef enum logic [1:0] {TX_NONE, TX_DEMAND, TX_AUTO} tx_mode_type;

  typedef struct packed {
    src_type     src;
    logic        normally_closed;
    logic        negative_polarity;
    logic        stable_qualified_activation;
    logic [9:0]  hysteresis;
    logic [9:0]  max_on;
    logic [9:0]  delay;
  } sp_cfg_type;

  typedef struct packed {
    logic signed [WEIGHT_W-1:0] net;
    logic signed [WEIGHT_W-1:0] gross;
    logic signed [WEIGHT_W-1:0] peak;
  } weight_bus_type;

  typedef struct packed {
    logic        zero_hold;
    tx_mode_type tx_mode;
    logic        in_test;
    logic        out_test;
    logic [1:0]  out_bits;
  } ctrl_type;

endpackage

// ### src/setpoint_channel.sv
`timescale 1ns/1ps
`default_nettype none

module setpoint_channel
  import relay_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       arst_n_in,
  input  wire logic                       tick_in,
  input  wire logic                       stable_in,
  input  wire logic signed [WEIGHT_W-1:0] weight_in,
  input  wire logic signed [WEIGHT_W-1:0] threshold_in,
  input  wire sp_cfg_type                 cfg_in,
  output logic                            active_out
);

  logic signed [WEIGHT_W+1:0] cmp_w;
  logic signed [WEIGHT_W+1:0] thr_w;
  logic signed [WEIGHT_W+1:0] rel_w;
  logic                       cond_r;
  logic                       cond_nxt;
  logic [9:0]                 dly_r;
  logic [9:0]                 dly_nxt;
  logic [9:0]                 on_r;
  logic [9:0]                 on_nxt;
  logic                       dly_done;
  logic                       expired;

  // ---------------------------------------------------------------------------
  // Compare with hysteresis
  // ---------------------------------------------------------------------------
  always_comb begin
    if (cfg_in.negative_polarity)
      cmp_w = -{{2{weight_in[WEIGHT_W-1]}}, weight_in};
    else
      cmp_w = {{2{weight_in[WEIGHT_W-1]}}, weight_in};
    thr_w = {{2{threshold_in[WEIGHT_W-1]}}, threshold_in};
    rel_w = thr_w - $signed({{(WEIGHT_W-8){1'b0}}, cfg_in.hysteresis});
    cond_nxt = cond_r;
    // Stability gates only the activation; release ignores it
    if (!cond_r && (cmp_w > thr_w) &&
        (stable_in || !cfg_in.stable_qualified_activation))
      cond_nxt = 1'b1;
    else if (cond_r && (cmp_w < rel_w))
      cond_nxt = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Delay and maximum-on timers
  // ---------------------------------------------------------------------------
  always_comb begin
    dly_done = (cfg_in.delay == 10'h000) || (dly_r >= cfg_in.delay);
    expired  = (cfg_in.max_on != 10'h000) && (on_r >= cfg_in.max_on);
    dly_nxt  = dly_r;
    on_nxt   = on_r;
    if (!cond_nxt) begin
      dly_nxt = 10'h000;
      on_nxt  = 10'h000;
    end else if (tick_in) begin
      if (!dly_done)
        dly_nxt = dly_r + 10'h001;
      else if (!expired && cfg_in.max_on != 10'h000)
        on_nxt = on_r + 10'h001;
    end
    active_out = cond_r && dly_done && !expired;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cond_r <= 1'b0;
      dly_r  <= 10'h000;
      on_r   <= 10'h000;
    end else begin
      cond_r <= cond_nxt;
      dly_r  <= dly_nxt;
      on_r   <= on_nxt;
    end
  end

endmodule

`default_nettype wire

// ### src/setpoint_relay_top.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

`include "relay_defs.svh"

// Function
// - With hold option on, zero key or input 1 held 5 s starts zero calibration.
// - Each setpoint compares net, gross or last peak; gross by default.
// - Normally-closed setting inverts the relay level; normally open by default.
// - Polarity selects positive or negative compared weight; positive by default.
// - Stable setting requires stable weight to activate; normal setting does not.
// - Hysteresis 0 to 999, default 2, relative to the threshold.
// - Maximum-on time forces the output off after its tenths of a second.
// - Activation delay: output on only after threshold exceeded for that time.
// - Zero for timer or delay disables that timing function.
// - Setpoint two has identical, independent options and state.
// - Input test reports inputs, input 1 leftmost, and suppresses input functions.
// - Output test drives outputs from set bits; LEDs mirror; setpoints suspended.
// - Demand mode: key or input 2 sends when stable and weight moved 20 divisions.
// - Automatic mode sends when stable above 20 divisions and moved 20 divisions.
module setpoint_relay_top
  import relay_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
)
(
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire weight_bus_type        weight_in,
  input  wire logic                  stable_in,
  input  wire logic                  zero_key_in,
  input  wire logic                  tx_key_in,
  input  wire logic [1:0]            logic_in,
  input  wire logic [7:0]            addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic [31:0]                rdata_out,
  output logic [NUM_SP-1:0]          relay_out,
  output logic [NUM_SP-1:0]          led_out,
  output logic                       zero_cal_out,
  output logic                       tx_req_out,
  output logic signed [WEIGHT_W-1:0] tx_weight_out
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  ctrl_type                   ctrl_r;
  ctrl_type                   ctrl_nxt;
  logic [15:0]                div_r;
  logic [15:0]                div_nxt;
  logic [31:0]                rdata_r;
  logic [31:0]                rdata_nxt;
  sp_cfg_type                 cfg_r     [NUM_SP];
  logic signed [WEIGHT_W-1:0] thr_r     [NUM_SP];
  logic [NUM_SP-1:0]          active;
  logic [NUM_SP-1:0]          relay_r;
  logic [NUM_SP-1:0]          relay_nxt;
  logic [NUM_SP-1:0]          led_r;
  logic [NUM_SP-1:0]          led_nxt;
  logic [TW-1:0]              tick_cnt_r;
  logic [TW-1:0]              tick_cnt_nxt;
  logic                       tick_r;
  logic                       tick_nxt;
  logic [3:0]                 meta_r;
  logic [3:0]                 sync_r;
  logic                       zkey;
  logic                       tkey;
  logic                       in1;
  logic                       in2;
  logic                       zero_src;
  logic                       zero_src_r;
  logic                       zero_done_r;
  logic                       zero_done_nxt;
  logic [7:0]                 zero_cnt_r;
  logic [7:0]                 zero_cnt_nxt;
  logic                       zero_cal_r;
  logic                       zero_cal_nxt;
  logic                       tx_src;
  logic                       tx_src_r;
  logic                       tx_req_r;
  logic                       tx_req_nxt;
  logic                       sent_r;
  logic                       sent_nxt;
  logic signed [WEIGHT_W-1:0] last_r;
  logic signed [WEIGHT_W-1:0] last_nxt;
  logic signed [WEIGHT_W+1:0] delta;
  logic signed [WEIGHT_W+1:0] min_chg;
  logic                       change_ok;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
    end else begin
      meta_r <= {tx_key_in, zero_key_in, logic_in};
      sync_r <= meta_r;
    end
  end

  always_comb begin
    in1  = sync_r[0];
    in2  = sync_r[1];
    zkey = sync_r[2];
    tkey = sync_r[3];
  end

  // ---------------------------------------------------------------------------
  // Tenth-second tick
  // ---------------------------------------------------------------------------
  always_comb begin
    tick_nxt     = (tick_cnt_r == TW'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + TW'(1);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Common registers and read port
  // ---------------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt  = div_r;
    if (wr_in && addr_in == `REG_CTRL) begin
      ctrl_nxt.zero_hold = wdata_in[`CTRL_ZHOLD];
      ctrl_nxt.tx_mode   = tx_mode_type'(wdata_in[`CTRL_TXMODE_LO +: 2]);
      ctrl_nxt.in_test   = wdata_in[`CTRL_IN_TEST];
      ctrl_nxt.out_test  = wdata_in[`CTRL_OUT_TEST];
      ctrl_nxt.out_bits  = wdata_in[`CTRL_OUT_BITS_LO +: 2];
    end
    // A zero division would make every change look sufficient
    if (wr_in && addr_in == `REG_DIV && wdata_in[15:0] != 16'h0000)
      div_nxt = wdata_in[15:0];
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        `REG_CTRL: begin
          rdata_nxt[`CTRL_ZHOLD]            = ctrl_r.zero_hold;
          rdata_nxt[`CTRL_TXMODE_LO +: 2]   = ctrl_r.tx_mode;
          rdata_nxt[`CTRL_IN_TEST]          = ctrl_r.in_test;
          rdata_nxt[`CTRL_OUT_TEST]         = ctrl_r.out_test;
          rdata_nxt[`CTRL_OUT_BITS_LO +: 2] = ctrl_r.out_bits;
        end
        `REG_DIV:    rdata_nxt[15:0] = div_r;
        `REG_STATUS: begin
          rdata_nxt[`STAT_INPUTS_LO +: 2] = {in1, in2};
          rdata_nxt[`STAT_RELAY_LO +: 2]  = relay_r;
          rdata_nxt[`STAT_ACTIVE_LO +: 2] = active;
          rdata_nxt[`STAT_STABLE]         = stable_in;
        end
        default: begin
          for (int i = 0; i < NUM_SP; i++) begin
            if (addr_in == 8'(`REG_SP_BASE + i * `REG_SP_STRIDE + `REG_SP_CFG)) begin
              rdata_nxt[`CFG_SRC_LO +: 2]  = cfg_r[i].src;
              rdata_nxt[`CFG_NC]           = cfg_r[i].normally_closed;
              rdata_nxt[`CFG_NEG]          = cfg_r[i].negative_polarity;
              rdata_nxt[`CFG_STABLE]       = cfg_r[i].stable_qualified_activation;
              rdata_nxt[`CFG_HYST_LO +: 10] = cfg_r[i].hysteresis;
            end
            if (addr_in == 8'(`REG_SP_BASE + i * `REG_SP_STRIDE + `REG_SP_THR))
              rdata_nxt = {{(32-WEIGHT_W){thr_r[i][WEIGHT_W-1]}}, thr_r[i]};
            if (addr_in == 8'(`REG_SP_BASE + i * `REG_SP_STRIDE + `REG_SP_TIME)) begin
              rdata_nxt[`TIME_MAXON_LO +: 10] = cfg_r[i].max_on;
              rdata_nxt[`TIME_DELAY_LO +: 10] = cfg_r[i].delay;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r  <= '{zero_hold: 1'b0, tx_mode: TX_NONE, in_test: 1'b0, out_test: 1'b0, out_bits: 2'h0};
      div_r   <= `RST_DIV;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      div_r   <= div_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Setpoint channels
  // ---------------------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_SP; g++) begin : g_sp
      sp_cfg_type                 cfg_nxt;
      logic signed [WEIGHT_W-1:0] thr_nxt;
      logic signed [WEIGHT_W-1:0] sel_w;
      logic [9:0]                 hyst_w;
      logic [9:0]                 maxon_w;
      logic [9:0]                 delay_w;

      always_comb begin
        cfg_nxt = cfg_r[g];
        thr_nxt = thr_r[g];
        hyst_w  = wdata_in[`CFG_HYST_LO +: 10];
        maxon_w = wdata_in[`TIME_MAXON_LO +: 10];
        delay_w = wdata_in[`TIME_DELAY_LO +: 10];
        if (wr_in && addr_in == 8'(`REG_SP_BASE + g * `REG_SP_STRIDE + `REG_SP_CFG)) begin
          cfg_nxt.src                         = src_type'(wdata_in[`CFG_SRC_LO +: 2]);
          cfg_nxt.normally_closed             = wdata_in[`CFG_NC];
          cfg_nxt.negative_polarity           = wdata_in[`CFG_NEG];
          cfg_nxt.stable_qualified_activation = wdata_in[`CFG_STABLE];
          cfg_nxt.hysteresis                  = (hyst_w > 10'd999) ? 10'd999 : hyst_w;
        end
        if (wr_in && addr_in == 8'(`REG_SP_BASE + g * `REG_SP_STRIDE + `REG_SP_THR))
          thr_nxt = wdata_in[WEIGHT_W-1:0];
        if (wr_in && addr_in == 8'(`REG_SP_BASE + g * `REG_SP_STRIDE + `REG_SP_TIME)) begin
          cfg_nxt.max_on = (maxon_w > 10'd999) ? 10'd999 : maxon_w;
          cfg_nxt.delay  = (delay_w > 10'd999) ? 10'd999 : delay_w;
        end
        // Peak source is the last acquired peak, whether or not peak is shown
        case (cfg_r[g].src)
          SRC_NET:  sel_w = weight_in.net;
          SRC_PEAK: sel_w = weight_in.peak;
          default:  sel_w = weight_in.gross;
        endcase
      end

      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          cfg_r[g] <= '{src: src_type'(`RST_SRC), normally_closed: 1'b0, negative_polarity: 1'b0,
                        stable_qualified_activation: 1'b0, hysteresis: `RST_HYST,
                        max_on: `RST_TIME, delay: `RST_TIME};
          thr_r[g] <= `RST_THR;
        end else begin
          cfg_r[g] <= cfg_nxt;
          thr_r[g] <= thr_nxt;
        end
      end

      setpoint_channel u_channel (
        .clk_in       (clk_in),
        .arst_n_in    (arst_n_in),
        .tick_in      (tick_r),
        .stable_in    (stable_in),
        .weight_in    (sel_w),
        .threshold_in (thr_r[g]),
        .cfg_in       (cfg_r[g]),
        .active_out   (active[g])
      );

      always_comb begin
        // Test bits replace the setpoint state; contact sense still applies
        led_nxt[g]   = ctrl_r.out_test ? ctrl_r.out_bits[g] : active[g];
        relay_nxt[g] = led_nxt[g] ^ cfg_r[g].normally_closed;
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      relay_r <= '0;
      led_r   <= '0;
    end else begin
      relay_r <= relay_nxt;
      led_r   <= led_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Zero request
  // ---------------------------------------------------------------------------
  always_comb begin
    zero_src      = zkey || (in1 && !ctrl_r.in_test);
    zero_cal_nxt  = 1'b0;
    zero_cnt_nxt  = zero_cnt_r;
    zero_done_nxt = zero_done_r;
    if (!zero_src) begin
      zero_cnt_nxt  = 8'h00;
      zero_done_nxt = 1'b0;
    end else if (!ctrl_r.zero_hold) begin
      zero_cal_nxt = !zero_src_r;
    end else if (!zero_done_r) begin
      // One calibration per press, however long the hold lasts
      if (zero_cnt_r >= 8'(`ZERO_HOLD_TICKS)) begin
        zero_cal_nxt  = 1'b1;
        zero_done_nxt = 1'b1;
      end else if (tick_r) begin
        zero_cnt_nxt = zero_cnt_r + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Weight transmission request
  // ---------------------------------------------------------------------------
  always_comb begin
    tx_src    = tkey || (in2 && !ctrl_r.in_test);
    min_chg   = $signed((WEIGHT_W+2)'(32'(div_r) * 32'(`CHANGE_DIVS)));
    delta     = {{2{weight_in.gross[WEIGHT_W-1]}}, weight_in.gross} -
                {{2{last_r[WEIGHT_W-1]}}, last_r};
    if (delta < 0)
      delta = -delta;
    change_ok  = !sent_r || (delta >= min_chg);
    tx_req_nxt = 1'b0;
    case (ctrl_r.tx_mode)
      TX_DEMAND: tx_req_nxt = tx_src && !tx_src_r && stable_in && change_ok;
      TX_AUTO:   tx_req_nxt = stable_in && change_ok &&
                              (weight_in.gross > min_chg);
      default:   tx_req_nxt = 1'b0;
    endcase
    sent_nxt = sent_r || tx_req_nxt;
    last_nxt = tx_req_nxt ? weight_in.gross : last_r;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      zero_src_r  <= 1'b0;
      zero_cnt_r  <= 8'h00;
      zero_done_r <= 1'b0;
      zero_cal_r  <= 1'b0;
      tx_src_r    <= 1'b0;
      tx_req_r    <= 1'b0;
      sent_r      <= 1'b0;
      last_r      <= '0;
    end else begin
      zero_src_r  <= zero_src;
      zero_cnt_r  <= zero_cnt_nxt;
      zero_done_r <= zero_done_nxt;
      zero_cal_r  <= zero_cal_nxt;
      tx_src_r    <= tx_src;
      tx_req_r    <= tx_req_nxt;
      sent_r      <= sent_nxt;
      last_r      <= last_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata_out     = rdata_r;
    relay_out     = relay_r;
    led_out       = led_r;
    zero_cal_out  = zero_cal_r;
    tx_req_out    = tx_req_r;
    tx_weight_out = last_r;
  end

endmodule

`default_nettype wire

// ### bench/relay_io_model.sv
`timescale 1ns/1ps
`default_nettype none

// Keys and logic input lines as the plant sees them; levels move only after an edge
module relay_io_model (
  input  wire logic       clk_in,
  output logic            zero_key_out,
  output logic            tx_key_out,
  output logic [1:0]      lines_out
);
  initial begin
    zero_key_out = 1'b0;
    tx_key_out   = 1'b0;
    lines_out    = 2'h0;
  end

  task automatic drive(input logic z, input logic t, input logic [1:0] l);
    @(posedge clk_in);
    zero_key_out <= z;
    tx_key_out   <= t;
    lines_out    <= l;
  endtask
endmodule

`default_nettype wire

// ### bench/setpoint_relay_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module setpoint_relay_top_chk
  import relay_pkg::*;
#(
  parameter int TICK_CYCLES = 10
)
(
  input wire logic                  clk_in,
  input wire logic                  arst_n_in,
  input wire weight_bus_type        weight_in,
  input wire logic                  stable_in,
  input wire logic [7:0]            addr_in,
  input wire logic                  rd_in,
  input wire logic [31:0]           rdata_out,
  input wire logic [NUM_SP-1:0]     relay_out,
  input wire logic                  zero_cal_out,
  input wire logic                  tx_req_out,
  input wire logic signed [WEIGHT_W-1:0] tx_weight_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ---------------------------------------------------------------------------
  // Pulses, transmission and status readback
  // ---------------------------------------------------------------------------
  property p_rd_idle; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_zero_pulse; zero_cal_out |=> !zero_cal_out; endproperty
  a_zero_pulse: assert property (p_zero_pulse) else $error("zero request too long");
  property p_tx_pulse; tx_req_out |=> !tx_req_out [*2]; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("send request too long");
  property p_tx_stable; tx_req_out |-> $past(stable_in); endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("send while unstable");
  property p_tx_weight; tx_req_out |-> tx_weight_out == $past(weight_in.gross); endproperty
  a_tx_weight: assert property (p_tx_weight) else $error("sent weight wrong");
  property p_stat_stable; rd_in && addr_in == 8'h20 |=> rdata_out[6] == $past(stable_in); endproperty
  a_stat_stable: assert property (p_stat_stable) else $error("status stable bit wrong");
  property p_stat_relay; rd_in && addr_in == 8'h20 |=> rdata_out[3:2] == $past(relay_out); endproperty
  a_stat_relay: assert property (p_stat_relay) else $error("status relay bits wrong");
  property p_unmapped; rd_in && addr_in > 8'h20 |=> rdata_out == 32'h0 ##1
    ($past(rd_in) || rdata_out == 32'h0); endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

`default_nettype wire

// ### bench/setpoint_relay_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module setpoint_relay_top_tb;
  import relay_pkg::*;
  logic                       clk_in    = 1'b0;
  logic                       arst_n_in = 1'b0;
  logic                       stable_in = 1'b0;
  logic                       wr_in     = 1'b0;
  logic                       rd_in     = 1'b0;
  weight_bus_type             weight_in = '0;
  logic [7:0]                 addr_in   = 8'h00;
  logic [31:0]                wdata_in  = 32'h0;
  logic [31:0]                rdata_out;
  logic [1:0]                 relay_out, led_out, lines;
  logic                       zero_cal_out, tx_req_out, zkey, tkey;
  logic signed [WEIGHT_W-1:0] tx_weight_out;
  int                         n_fail = 0, n_tests = 0, n_zero = 0, n_tx = 0, k;

  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    n_zero <= n_zero + int'(zero_cal_out);
    n_tx   <= n_tx + int'(tx_req_out);
  end

  relay_io_model relay_io_model_inst (.clk_in(clk_in), .zero_key_out(zkey), .tx_key_out(tkey), .lines_out(lines));
  setpoint_relay_top #(.TICK_CYCLES(10)) setpoint_relay_top_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .weight_in(weight_in), .stable_in(stable_in),
    .zero_key_in(zkey), .tx_key_in(tkey), .logic_in(lines), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .relay_out(relay_out), .led_out(led_out), .zero_cal_out(zero_cal_out),
    .tx_req_out(tx_req_out), .tx_weight_out(tx_weight_out));

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out & m, exp);
  endtask
  // Bounded wait: a fast bound also proves that zero timers add no delay
  task automatic led_is(input logic [1:0] v, input int n);
    repeat (n) @(posedge clk_in);
    #1 chk(32'(led_out), 32'(v));
  endtask
  task automatic gross(input int g, input logic [1:0] v, input int n);
    @(posedge clk_in);
    weight_in.gross <= WEIGHT_W'(g);
    led_is(v, n);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 2; i++) rd(8'(4 + 12 * i), 32'h0002_0001, '1);
    rd(8'h0c, 32'h0, '1);
    rd(8'h40, 32'h0, '1);
    $display("test reset done");
    wr(8'h08, 32'd100);
    wr(8'h14, 32'd999);
    for (int s = 0; s < 3; s++) begin
      wr(8'h04, 32'h0002_0000 | s);
      @(posedge clk_in);
      weight_in <= '{net: WEIGHT_W'((s == 0) ? 150 : 0), gross: WEIGHT_W'((s == 1) ? 150 : 0),
                     peak: WEIGHT_W'((s == 2) ? 150 : 0)};
      led_is(2'h1, 6);
      @(posedge clk_in);
      weight_in <= '0;
      led_is(2'h0, 6);
    end
    wr(8'h04, 32'h0002_0001);
    gross(100, 2'h0, 20);
    gross(101, 2'h1, 6);
    gross(98, 2'h1, 20);
    gross(97, 2'h0, 6);
    wr(8'h04, 32'h0002_0009);
    gross(-150, 2'h1, 6);
    gross(150, 2'h0, 6);
    wr(8'h04, 32'h0002_0005);
    gross(0, 2'h0, 6);
    rd(8'h20, 32'h4, 32'hc);
    wr(8'h04, 32'h0002_0011);
    gross(150, 2'h0, 20);
    @(posedge clk_in) stable_in <= 1'b1;
    led_is(2'h1, 6);
    $display("test compare done");
    wr(8'h04, 32'h0002_0001);
    gross(0, 2'h0, 6);
    wr(8'h0c, 32'h0003_0000);
    gross(150, 2'h0, 15);
    led_is(2'h1, 40);
    gross(0, 2'h0, 6);
    wr(8'h0c, 32'h0000_0002);
    gross(150, 2'h1, 6);
    led_is(2'h0, 40);
    gross(160, 2'h0, 40);
    wr(8'h14, 32'd50);
    gross(75, 2'h2, 6);
    wr(8'h00, 32'h30);
    led_is(2'h1, 6);
    $display("test timers done");
    wr(8'h00, 32'h08);
    k = n_zero;
    relay_io_model_inst.drive(1'b0, 1'b0, 2'h1);
    repeat (10) @(posedge clk_in);
    rd(8'h20, 32'h2, 32'h3);
    chk(32'(n_zero), 32'(k));
    wr(8'h00, 32'h01);
    relay_io_model_inst.drive(1'b0, 1'b0, 2'h0);
    relay_io_model_inst.drive(1'b0, 1'b0, 2'h1);
    repeat (400) @(posedge clk_in);
    chk(32'(n_zero), 32'(k));
    repeat (150) @(posedge clk_in);
    chk(32'(n_zero), 32'(k + 1));
    relay_io_model_inst.drive(1'b0, 1'b0, 2'h0);
    $display("test inputs done");
    wr(8'h00, 32'h02);
    gross(100, 2'h2, 1);
    for (int j = 0; j < 3; j++) begin
      if (j == 2) weight_in.gross <= 24'sd130;
      k = n_tx;
      relay_io_model_inst.drive(1'b0, 1'b1, 2'h0);
      relay_io_model_inst.drive(1'b0, 1'b0, 2'h0);
      repeat (10) @(posedge clk_in);
      chk(32'(n_tx), 32'(k + (j != 1)));
      chk(32'(tx_weight_out), (j == 2) ? 32'd130 : 32'd100);
    end
    wr(8'h00, 32'h04);
    k = n_tx;
    gross(10, 2'h0, 20);
    chk(32'(n_tx), 32'(k));
    gross(200, 2'h2, 40);
    chk(32'(n_tx), 32'(k + 1));
    $display("test transmit done");
    wrap_up();
  end
endmodule

bind setpoint_relay_top setpoint_relay_top_chk #(.TICK_CYCLES(TICK_CYCLES)) setpoint_relay_top_chk_inst (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .weight_in(weight_in), .stable_in(stable_in), .addr_in(addr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .relay_out(relay_out), .zero_cal_out(zero_cal_out),
  .tx_req_out(tx_req_out), .tx_weight_out(tx_weight_out));

`default_nettype wire
